// ---- verilog/tg_regs.vh ----
/*
  Register offsets, field positions, reset values and timing figures of the
  dual tone generator. Assumes an APB slave with 32-bit data and byte addresses.
*/
`ifndef TG_REGS_VH
`define TG_REGS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define TG_OFS_TONE_ONE 8'h00
`define TG_OFS_TONE_TWO 8'h04
`define TG_OFS_MODE 8'h08
`define TG_OFS_STATUS 8'h0C

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define TG_DIV_W 8
`define TG_DIV_RESET 8'h00
`define TG_DIV_OFF 8'h00
`define TG_DIV_DC 8'h01
`define TG_MODE_HS_BIT 0
`define TG_MODE_RESET 1'b0
`define TG_ST_ONE_ACT 0
`define TG_ST_ONE_DC 1
`define TG_ST_TWO_ACT 2
`define TG_ST_TWO_DC 3
`define TG_ST_HS 4

// ****************************************************************
// Sample levels and timing
// ****************************************************************
`define TG_SAMPLE_MID 8'h80
`define TG_SAMPLE_OFF 8'h00
`define TG_SRC_HZ 85300
`define TG_CLK_HZ 40000000
`define TG_ACC_W 19

`endif

// ---- verilog/tg_tone_gen.v ----
/*
  One tone generator: steps a 32-point sine table over N source ticks.
  Assumes a one-cycle tick at the source rate and a code from a register.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tg_regs.vh"

module tg_tone_gen #(
  parameter DIV_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire run,
  input wire [DIV_W-1:0] code,
  output reg [7:0] sample_reg,
  output reg active_reg,
  output reg dc_reg
);

  reg [DIV_W-1:0] cur_reg;
  reg [DIV_W-1:0] cnt_reg;
  wire [DIV_W+4:0] scaled;
  wire [DIV_W+4:0] quot;
  wire at_wrap;
  wire idle;

  // ****************************************************************
  // Sine lookup
  // ****************************************************************
  function [6:0] tg_quarter;
    input [3:0] j;
    begin
      case (j)
        4'h0: tg_quarter = 7'h00;
        4'h1: tg_quarter = 7'h19;
        4'h2: tg_quarter = 7'h31;
        4'h3: tg_quarter = 7'h47;
        4'h4: tg_quarter = 7'h5A;
        4'h5: tg_quarter = 7'h6A;
        4'h6: tg_quarter = 7'h75;
        4'h7: tg_quarter = 7'h7D;
        default: tg_quarter = 7'h7F;
      endcase
    end
  endfunction

  // Offset-binary sine built from one quarter by symmetry
  function [7:0] tg_sine;
    input [4:0] idx;
    reg [6:0] mag;
    reg [4:0] mirror;
    begin
      mirror = 5'h10 - {1'b0, idx[3:0]};
      mag = (idx[3:0] <= 4'h8) ? tg_quarter(idx[3:0]) : tg_quarter(mirror[3:0]);
      tg_sine = idx[4] ? (`TG_SAMPLE_MID - {1'b0, mag}) : (`TG_SAMPLE_MID + {1'b0, mag});
    end
  endfunction

  // Table index is (cnt*32+16)/N, so one full sine spans N ticks. Each
  // tick is read at the middle of its slot: at code two the points fall
  // at a quarter and three quarters of the period, not both at mid level.
  assign scaled = {cnt_reg, 5'h00} + {{DIV_W{1'b0}}, 5'h10};
  assign quot = (cur_reg > `TG_DIV_DC) ? (scaled / {5'h00, cur_reg}) : {(DIV_W+5){1'b0}};
  assign at_wrap = tick && (cnt_reg == cur_reg - 8'h01);
  assign idle = (cur_reg == `TG_DIV_OFF) || (cur_reg == `TG_DIV_DC);

  // ****************************************************************
  // Period counter and sample register
  // ****************************************************************
  // A running tone takes a new code only at a period boundary (off and bias
  // take it at once), so only clearing the mode bit cuts it halfway through its waveform.
  always @(posedge clk) begin
    if (!rst_n) begin
      cur_reg <= `TG_DIV_RESET;
      cnt_reg <= {DIV_W{1'b0}};
      sample_reg <= `TG_SAMPLE_OFF;
      active_reg <= 1'b0;
      dc_reg <= 1'b0;
    end else if (!run) begin
      cur_reg <= `TG_DIV_OFF;
      cnt_reg <= {DIV_W{1'b0}};
      sample_reg <= `TG_SAMPLE_OFF;
      active_reg <= 1'b0;
      dc_reg <= 1'b0;
    end else begin
      if (idle || at_wrap) begin
        cur_reg <= code;
        cnt_reg <= {DIV_W{1'b0}};
      end else if (tick) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      active_reg <= (cur_reg > `TG_DIV_DC);
      dc_reg <= (cur_reg == `TG_DIV_DC);
      if (cur_reg == `TG_DIV_OFF) begin
        sample_reg <= `TG_SAMPLE_OFF;
      end else if (cur_reg == `TG_DIV_DC) begin
        sample_reg <= `TG_SAMPLE_MID;
      end else begin
        sample_reg <= tg_sine(quot[4:0]);
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/tg_top.v ----
/*
  Dual tone generator with APB register access: two divider registers,
  a mode register and a status register; sine samples out for a DAC.
  Assumes REF_CLK at 40 MHz, synchronous active-low reset, APB master.
*/
// Functional notes
// - Sine at 85.3 kHz divided by code
// - Code one gives steady DC bias
// - Code zero powers generator off
// - Tones run only in high-speed mode
// - Two generators independent, outputs mixed
// - One active code gives single tone
// - Second generator uses same encoding
`timescale 1ns/1ps
`default_nettype none
`include "tg_regs.vh"

module tg_top #(
  parameter DIV_W = 8,
  parameter ADDR_W = 8
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  output wire [7:0] TONE_ONE_SAMPLE,
  output wire [7:0] TONE_TWO_SAMPLE,
  output reg [8:0] TONE_MIX,
  output reg TONE_POWER
);

  // ****************************************************************
  // Source tick generation
  // ****************************************************************
  // Both rates are divided by 100 so the accumulator stays narrow
  localparam integer TICK_NUM_I = `TG_SRC_HZ / 100;
  localparam integer TICK_DEN_I = `TG_CLK_HZ / 100;
  localparam [`TG_ACC_W-1:0] TICK_NUM = TICK_NUM_I[`TG_ACC_W-1:0];
  localparam [`TG_ACC_W-1:0] TICK_DEN = TICK_DEN_I[`TG_ACC_W-1:0];

  reg [`TG_ACC_W-1:0] acc_reg;
  reg tick_reg;
  wire [`TG_ACC_W-1:0] acc_sum;

  reg [DIV_W-1:0] tone_one_divider_reg;
  reg [DIV_W-1:0] tone_two_divider_reg;
  reg high_speed_clock_select_reg;

  wire one_act;
  wire one_dc;
  wire two_act;
  wire two_dc;
  reg [7:0] status_byte;

  wire setup_ph;
  wire access_ph;
  wire hit_one;
  wire hit_two;
  wire hit_mode;
  wire hit_status;
  wire hit_any;

  // Never wraps: the largest remainder plus one step fits the width
  assign acc_sum = acc_reg + TICK_NUM;

  // Fractional accumulator: one tick per 40 MHz / 85.3 kHz on average.
  // Jitter is one REF_CLK period, far below audible effect.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      acc_reg <= {`TG_ACC_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (acc_sum >= TICK_DEN) begin
      acc_reg <= acc_sum - TICK_DEN;
      tick_reg <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Register map
  // ****************************************************************
  // 0x00 first divider, 0x04 second divider: bits 7:0 hold the code N.
  //   N >= 2 runs a sine of 85.3 kHz / N, N = 1 holds the bias level,
  //   N = 0 powers the generator off.
  // 0x08 mode: bit 0 selects the high-speed clock; both tones stay
  //   silent while it is low, whatever codes are loaded.
  // 0x0C status, read only: bit 0/1 first generator running/bias,
  //   bit 2/3 second generator running/bias, bit 4 mode.
  // Upper bits read zero and are ignored on write; any other address
  // answers with an error and changes nothing.

  // ****************************************************************
  // APB address decode
  // ****************************************************************
  // Phase and address decode; each hit is a plain compare
  assign setup_ph = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;
  assign hit_one = (PADDR == `TG_OFS_TONE_ONE);
  assign hit_two = (PADDR == `TG_OFS_TONE_TWO);
  assign hit_mode = (PADDR == `TG_OFS_MODE);
  assign hit_status = (PADDR == `TG_OFS_STATUS);
  assign hit_any = hit_one || hit_two || hit_mode || hit_status;

  // Zero wait states; unmapped addresses and writes to status fail
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph && (!hit_any || (PWRITE && hit_status));

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Each divider is written on its own, so either tone can be set
  // without disturbing the other one.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      tone_one_divider_reg <= `TG_DIV_RESET;
      tone_two_divider_reg <= `TG_DIV_RESET;
      high_speed_clock_select_reg <= `TG_MODE_RESET;
    end else if (access_ph && PWRITE) begin
      if (hit_one) begin
        tone_one_divider_reg <= PWDATA[DIV_W-1:0];
      end else if (hit_two) begin
        tone_two_divider_reg <= PWDATA[DIV_W-1:0];
      end else if (hit_mode) begin
        high_speed_clock_select_reg <= PWDATA[`TG_MODE_HS_BIT];
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Status bits sit where the header places them; spare bits read zero
  always @* begin
    status_byte = 8'h00;
    status_byte[`TG_ST_ONE_ACT] = one_act;
    status_byte[`TG_ST_ONE_DC] = one_dc;
    status_byte[`TG_ST_TWO_ACT] = two_act;
    status_byte[`TG_ST_TWO_DC] = two_dc;
    status_byte[`TG_ST_HS] = high_speed_clock_select_reg;
  end

  // Read data is captured in the setup cycle so it comes from a flop
  // and stands for the whole access cycle.
  // A read of an unmapped address returns zero.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (setup_ph && !PWRITE) begin
      if (hit_one) begin
        PRDATA <= {24'h000000, tone_one_divider_reg};
      end else if (hit_two) begin
        PRDATA <= {24'h000000, tone_two_divider_reg};
      end else if (hit_mode) begin
        PRDATA <= {31'h00000000, high_speed_clock_select_reg};
      end else if (hit_status) begin
        PRDATA <= {24'h000000, status_byte};
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Tone generators
  // ****************************************************************
  // Both instances share one module, so the code meanings are identical
  // for the two dividers; they share the source tick and the mode bit as run.
  tg_tone_gen #(
    .DIV_W(DIV_W)
  ) u_tone_one (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .tick(tick_reg),
    .run(high_speed_clock_select_reg),
    .code(tone_one_divider_reg),
    .sample_reg(TONE_ONE_SAMPLE),
    .active_reg(one_act),
    .dc_reg(one_dc)
  );

  tg_tone_gen #(
    .DIV_W(DIV_W)
  ) u_tone_two (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .tick(tick_reg),
    .run(high_speed_clock_select_reg),
    .code(tone_two_divider_reg),
    .sample_reg(TONE_TWO_SAMPLE),
    .active_reg(two_act),
    .dc_reg(two_dc)
  );

  // ****************************************************************
  // Mixer and power indication
  // ****************************************************************
  // Plain sum of the two offset-binary samples; with one generator off
  // its zero sample leaves the other tone alone on the mix.
  // Nine bits hold the largest sum, so the mix never wraps.
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      TONE_MIX <= 9'h000;
      TONE_POWER <= 1'b0;
    end else begin
      TONE_MIX <= {1'b0, TONE_ONE_SAMPLE} + {1'b0, TONE_TWO_SAMPLE};
      TONE_POWER <= one_act || one_dc || two_act || two_dc;
    end
  end

endmodule
`default_nettype wire

// ---- dv/tg_line_mon.sv ----
/*
  Line-side listener: measures the tone period of one sample stream.
  Assumes offset-binary samples, one per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tg_line_mon (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sample,
  output logic [15:0] period,
  output logic [7:0] edges
);
  logic [15:0] cnt;
  logic [7:0] prev;
  // Upward mid-level crossings bound one period; DC never crosses
  always @(posedge clk) begin
    prev <= sample;
    cnt <= cnt + 16'h1;
    if (!rst_n) begin
      cnt <= 16'h0;
      edges <= 8'h00;
      period <= 16'h0;
    end else if (prev < 8'h80 && sample >= 8'h80) begin
      period <= cnt;
      cnt <= 16'h1;
      edges <= edges + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tg_top_sva.sv ----
/*
  Checker of the tone block: bus answers and tone levels per code.
  Assumes it is bound to tg_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tg_top_sva #(
  parameter DIV_W = 8,
  parameter ADDR_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [7:0] TONE_ONE_SAMPLE,
  input wire logic [7:0] TONE_TWO_SAMPLE,
  input wire logic [8:0] TONE_MIX,
  input wire logic TONE_POWER
);
  logic [DIV_W-1:0] c1_reg, c2_reg;
  logic mode_reg, idle1_reg, idle2_reg, wr_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  // ****************
  // Register shadow
  // ****************
  // Idle flags: a running tone holds its code until wrap, so level checks skip it
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      c1_reg <= '0;
      c2_reg <= '0;
      mode_reg <= 1'b0;
      idle1_reg <= 1'b1;
      idle2_reg <= 1'b1;
    end else begin
      if (wr_acc && PADDR == 8'h00) c1_reg <= PWDATA[DIV_W-1:0];
      if (wr_acc && PADDR == 8'h04) c2_reg <= PWDATA[DIV_W-1:0];
      if (wr_acc && PADDR == 8'h08) mode_reg <= PWDATA[0];
      idle1_reg <= !mode_reg || (idle1_reg && c1_reg < 8'h02);
      idle2_reg <= !mode_reg || (idle2_reg && c2_reg < 8'h02);
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ready_tied_a: assert property (PREADY) else $error("ready low");
  err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray error");
  err_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h0C |-> PSLVERR)
    else $error("unmapped access accepted");
  rd_one_a: assert property (PSEL && PENABLE && !PWRITE && PADDR == 8'h00 |->
    PRDATA == 32'(c1_reg)) else $error("first divider readback wrong");
  mix_sum_a: assert property (TONE_MIX == $past(TONE_ONE_SAMPLE) + $past(TONE_TWO_SAMPLE))
    else $error("mix not the sum");
  mode_off_a: assert property ((!mode_reg)[*4] |-> TONE_ONE_SAMPLE == 8'h00 &&
    TONE_TWO_SAMPLE == 8'h00 && !TONE_POWER) else $error("tone outside fast mode");
  dc_one_a: assert property ((idle1_reg && mode_reg && c1_reg == 8'h01)[*4] |->
    TONE_ONE_SAMPLE == 8'h80 && TONE_POWER) else $error("no bias level");
  off_two_a: assert property ((idle2_reg && mode_reg && c2_reg == 8'h00)[*4] |->
    TONE_TWO_SAMPLE == 8'h00) else $error("second generator not off");
  cover property (mode_reg && c1_reg == 8'h28);
  cover property (PSLVERR);
  cover property (TONE_MIX > 9'h100);
endmodule
bind tg_top tg_top_sva #(.DIV_W(DIV_W), .ADDR_W(ADDR_W)) i_sva (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TONE_ONE_SAMPLE(TONE_ONE_SAMPLE), .TONE_TWO_SAMPLE(TONE_TWO_SAMPLE),
  .TONE_MIX(TONE_MIX), .TONE_POWER(TONE_POWER));
`default_nettype wire

// ---- dv/tg_top_bench.sv ----
/*
  Self-checking bench: APB tasks, register and tone period scenarios.
  Assumes the line monitors and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tg_top_bench;
  logic clk, rst_n, psel, penable, pwrite, slverr, ready, power, e;
  logic [7:0] paddr, s1, s2, ed1, ed2;
  logic [31:0] pwdata, rdata, r;
  logic [8:0] mix;
  logic [15:0] per1, per2;
  logic [7:0] codes [12] = '{8'h7A, 8'h6F, 8'h64, 8'h5B, 8'h47, 8'h40, 8'h3A, 8'h34,
    8'h27, 8'h42, 8'h29, 8'h1F};
  int mismatches, check_count;
  tg_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(rdata), .PREADY(ready),
    .PSLVERR(slverr), .TONE_ONE_SAMPLE(s1), .TONE_TWO_SAMPLE(s2), .TONE_MIX(mix),
    .TONE_POWER(power));
  tg_line_mon i_mon1 (.clk(clk), .rst_n(rst_n), .sample(s1), .period(per1), .edges(ed1));
  tg_line_mon i_mon2 (.clk(clk), .rst_n(rst_n), .sample(s2), .period(per2), .edges(ed2));
  // ****************
  // Tasks
  // ****************
  task finish_test;
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // Request held until ready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 16);
    if (ready !== 1'b1) begin
      mismatches++;
      finish_test;
    end
    r = rdata;
    e = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // Bounded wait for new mid-level crossings on each line
  task wait_cross(input logic [7:0] n1, input logic [7:0] n2);
    logic [7:0] b1, b2;
    int n;
    b1 = ed1;
    b2 = ed2;
    n = 0;
    while ((8'(ed1 - b1) < n1 || 8'(ed2 - b2) < n2) && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60000) begin
      mismatches++;
      finish_test;
    end
  endtask
  // Period in cycles is code * 40 MHz / 85.3 kHz, within three cycles
  task chk_per(input logic [15:0] p, input int code);
    int d;
    d = int'(p) * 853 - code * 400000;
    chk(32'(d <= 2559 && d >= -2559), 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} <= '0;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 8'h0C, 32'h1F);
    chk(32'(e), 32'h1);
    foreach (codes[i]) begin
      apb(1'b1, 8'h00, {24'hA5A5A5, codes[i]});
      rd(8'h00, 32'(codes[i]));
      apb(1'b1, 8'h04, 32'(codes[i]));
      rd(8'h04, 32'(codes[i]));
    end
    repeat (8) @(posedge clk);
    chk({s1, s2, 15'h0, power}, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    repeat (8) @(posedge clk);
    chk({s1, s2, 7'h0, mix}, 32'h8000_0080);
    chk(32'(power), 32'h1);
    rd(8'h0C, 32'h12);
    apb(1'b1, 8'h00, 32'h28);
    apb(1'b1, 8'h04, 32'h1F);
    wait_cross(8'h02, 8'h02);
    chk_per(per1, 40);
    chk_per(per2, 31);
    apb(1'b1, 8'h00, 32'h02);
    wait_cross(8'h03, 8'h00);
    chk_per(per1, 2);
    finish_test;
  end
endmodule
`default_nettype wire
